// *** core/adcc_ctrl.sv ***
// converter control block: control register two, both sample time registers,
// injected triggers, calibration and the conversion sequencer.
// assumes trigger events are same-clock pulses and channels come from outside.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Injected trigger codes 001 to 111 pick timer 1 capture 4, timer 2 trigger out, timer 2 capture 1, timer 3 capture 4, timer 4 trigger out, line 15, software bit.
// - Injected trigger code 000 picks the timer 1 trigger output.
// - An external injected trigger starts a conversion only while its enable bit is 1.
// - Software sets the injected start bit and the block clears it once the conversion starts.
// - Bit 8 enables DMA requests for regular results, off after reset.
// - Bit 3 asks for the calibration register to be cleared and drops when that is done.
// - A calibration reset asked during a conversion waits for it to end, taking extra cycles.
// - Bit 2 starts calibration, stays 1 while calibrating and drops at the end.
// - With bit 1 set regular conversions repeat back to back; injected ones and all others run one per start.
// - Writing 1 to the on bit while it is 0 only powers up the converter.
// - Writing 1 to the on bit while it is 1 starts a conversion.
// - Clearing the on bit stops conversion and calibration and powers down.
// - The on-bit start happens only when no other bit changes in the same write.
// - Sample codes 000 to 111 give 2 to 240 cycles of sampling, the 1.5 to 239.5 half-cycle lengths rounded up.
// - Channels 10 to 17 sit in the high register bits 23:0, channels 0 to 9 in the low one bits 29:0.
module adcc_ctrl
	import adcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire adcc_bus_t bus,
	output logic [31:0] rdata,
	input wire logic [6:0] inj_events,
	input wire logic [CH_W-1:0] regular_channel,
	input wire logic [CH_W-1:0] injected_channel,
	output adcc_conv_t conv_status,
	output logic conv_start,
	output logic conv_end,
	output logic dma_request,
	output logic dma_enable,
	output logic align_left,
	output logic cal_clear
);

	localparam int CALIBRATION_RESET_BOUND = 300;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	adcc_state_t state_reg;
	logic converter_on_reg, continuous_conversion_reg, dma_reg, align_reg, injected_external_trigger_enable_reg;
	logic injected_software_start_reg, calibrate_reg, calibration_reset_reg, reg_pending_reg;
	logic [2:0] injected_trigger_select_reg;
	logic [23:0] smp_hi_reg;
	logic [29:0] smp_lo_reg;
	logic [31:0] rdata_reg, ctl_now;
	logic [CNT_W-1:0] cnt_reg, rst_cnt_reg;
	logic [CH_W-1:0] cur_ch_reg;
	logic cur_inj_reg, smp_start_reg, conv_end_reg, dma_req_reg, cal_clear_reg;
	logic ctl_wr, other_changed, on_start, power_off, inj_go, inj_from_sw, jsw_taken;
	logic cal_done, calibration_reset_done, smp_done, smp_busy;
	logic [SMP_W-1:0] ch_code [NCH];
	logic [SMP_W-1:0] cur_code;

	// current view of the writable control bits
	always_comb begin
		ctl_now = CTL2_RESET;
		ctl_now[BIT_ON] = converter_on_reg;
		ctl_now[BIT_CONTINUOUS_CONVERSION] = continuous_conversion_reg;
		ctl_now[BIT_CAL] = calibrate_reg;
		ctl_now[BIT_CALIBRATION_RESET] = calibration_reset_reg;
		ctl_now[BIT_DMA] = dma_reg;
		ctl_now[BIT_ALIGN] = align_reg;
		ctl_now[JSEL_LSB +: 3] = injected_trigger_select_reg;
		ctl_now[BIT_JEXT] = injected_external_trigger_enable_reg;
		ctl_now[BIT_JSW] = injected_software_start_reg;
	end

	// write decode; the on-bit start needs every other bit to stay put
	assign ctl_wr = bus.wr && (bus.addr == OFS_CTL2);
	assign other_changed = (((bus.wdata ^ ctl_now) & CTL2_RW_MASK) >> 1) != 32'h00000000;
	assign on_start = ctl_wr && bus.wdata[BIT_ON] && converter_on_reg && !other_changed;
	assign power_off = ctl_wr && !bus.wdata[BIT_ON];

	// plain control fields
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			converter_on_reg <= CTL2_RESET[BIT_ON];
			continuous_conversion_reg <= CTL2_RESET[BIT_CONTINUOUS_CONVERSION];
			dma_reg <= CTL2_RESET[BIT_DMA];
			align_reg <= CTL2_RESET[BIT_ALIGN];
			injected_trigger_select_reg <= CTL2_RESET[JSEL_LSB +: 3];
			injected_external_trigger_enable_reg <= CTL2_RESET[BIT_JEXT];
		end else if (ctl_wr) begin
			converter_on_reg <= bus.wdata[BIT_ON];
			continuous_conversion_reg <= bus.wdata[BIT_CONTINUOUS_CONVERSION];
			dma_reg <= bus.wdata[BIT_DMA];
			align_reg <= bus.wdata[BIT_ALIGN];
			injected_trigger_select_reg <= bus.wdata[JSEL_LSB +: 3];
			injected_external_trigger_enable_reg <= bus.wdata[BIT_JEXT];
		end
	end

	// software start bit: a write beats the hardware clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			injected_software_start_reg <= CTL2_RESET[BIT_JSW];
		end else if (ctl_wr) begin
			injected_software_start_reg <= bus.wdata[BIT_JSW];
		end else if (jsw_taken) begin
			injected_software_start_reg <= 1'b0;
		end
	end

	// calibration bits: power-down wins, then a software set, then the clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			calibrate_reg <= CTL2_RESET[BIT_CAL];
			calibration_reset_reg <= CTL2_RESET[BIT_CALIBRATION_RESET];
		end else begin
			if (power_off) begin
				calibrate_reg <= 1'b0;
			end else if (ctl_wr && bus.wdata[BIT_CAL]) begin
				calibrate_reg <= 1'b1;
			end else if (cal_done) begin
				calibrate_reg <= 1'b0;
			end
			if (power_off) begin
				calibration_reset_reg <= 1'b0;
			end else if (ctl_wr && bus.wdata[BIT_CALIBRATION_RESET]) begin
				calibration_reset_reg <= 1'b1;
			end else if (calibration_reset_done) begin
				calibration_reset_reg <= 1'b0;
			end
		end
	end

	// calibration reset counts only outside a conversion, so a busy one adds cycles
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rst_cnt_reg <= '0;
		end else if (!calibration_reset_reg || calibration_reset_done) begin
			rst_cnt_reg <= '0;
		end else if (state_reg != ST_SAMPLE && state_reg != ST_CONVERT) begin
			rst_cnt_reg <= rst_cnt_reg + CNT_W'(1);
		end
	end
	assign calibration_reset_done = calibration_reset_reg && (rst_cnt_reg == CNT_W'(CALIBRATION_RESET_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cal_clear_reg <= 1'b0;
		end else begin
			cal_clear_reg <= calibration_reset_done && !power_off;
		end
	end

	// sample time registers, reserved bits kept at zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			smp_hi_reg <= SMP_RESET[23:0];
			smp_lo_reg <= SMP_RESET[29:0];
		end else if (bus.wr && bus.addr == OFS_SMP_HI) begin
			smp_hi_reg <= bus.wdata[23:0];
		end else if (bus.wr && bus.addr == OFS_SMP_LO) begin
			smp_lo_reg <= bus.wdata[29:0];
		end
	end

	// per-channel view of the sample codes, each independent
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		if (g < HI_FIRST_CH) begin : g_lo
			assign ch_code[g] = smp_lo_reg[g*SMP_W +: SMP_W];
		end else begin : g_hi
			assign ch_code[g] = smp_hi_reg[(g-HI_FIRST_CH)*SMP_W +: SMP_W];
		end
	end
	// code is read live; software must not change it mid sample
	assign cur_code = (cur_ch_reg < CH_W'(NCH)) ? ch_code[cur_ch_reg] : SMP_W'(0);

	// read data stands one cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!rst_b || !bus.rd) begin
			rdata_reg <= 32'h00000000;
		end else begin
			case (bus.addr)
				OFS_CTL2: rdata_reg <= ctl_now;
				OFS_SMP_HI: rdata_reg <= {8'h00, smp_hi_reg} & SMP_HI_MASK;
				OFS_SMP_LO: rdata_reg <= {2'h0, smp_lo_reg} & SMP_LO_MASK;
				default: rdata_reg <= 32'h00000000;
			endcase
		end
	end

	adcc_inj_trig u_trig (
		.sel(injected_trigger_select_reg),
		.ext_en(injected_external_trigger_enable_reg),
		.sw_start(injected_software_start_reg),
		.events(inj_events),
		.go(inj_go),
		.from_sw(inj_from_sw)
	);

	adcc_smp_timer u_smp (
		.clk(clk),
		.rst_b(rst_b),
		.start(smp_start_reg),
		.code(cur_code),
		.busy(smp_busy),
		.done(smp_done)
	);

	// injected start taken only when idle; later events are dropped
	assign jsw_taken = (state_reg == ST_IDLE) && !calibrate_reg && inj_go && inj_from_sw && !power_off;
	assign cal_done = (state_reg == ST_CAL) && (cnt_reg == CNT_W'(CAL_CYCLES - 1));

	// regular start waits in a pending flag until the sequencer is idle
	always_ff @(posedge clk) begin
		if (!rst_b || power_off) begin
			reg_pending_reg <= 1'b0;
		end else if (on_start) begin
			reg_pending_reg <= 1'b1;
		end else if (state_reg == ST_IDLE && !calibrate_reg && !inj_go) begin
			reg_pending_reg <= 1'b0;
		end
	end

	// sequencer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= ST_OFF;
			cnt_reg <= '0;
			cur_ch_reg <= '0;
			cur_inj_reg <= 1'b0;
			smp_start_reg <= 1'b0;
			conv_end_reg <= 1'b0;
			dma_req_reg <= 1'b0;
		end else begin
			smp_start_reg <= 1'b0;
			conv_end_reg <= 1'b0;
			dma_req_reg <= 1'b0;
			if (power_off) begin
				state_reg <= ST_OFF;
				cnt_reg <= '0;
			end else begin
				case (state_reg)
					ST_OFF: begin
						if (ctl_wr && bus.wdata[BIT_ON]) begin
							state_reg <= ST_IDLE;
						end
					end
					ST_IDLE: begin
						cnt_reg <= '0;
						if (calibrate_reg) begin
							state_reg <= ST_CAL;
						end else if (inj_go) begin
							state_reg <= ST_SAMPLE;
							cur_ch_reg <= injected_channel;
							cur_inj_reg <= 1'b1;
							smp_start_reg <= 1'b1;
						end else if (reg_pending_reg) begin
							state_reg <= ST_SAMPLE;
							cur_ch_reg <= regular_channel;
							cur_inj_reg <= 1'b0;
							smp_start_reg <= 1'b1;
						end
					end
					ST_CAL: begin
						cnt_reg <= cnt_reg + CNT_W'(1);
						if (cal_done) begin
							state_reg <= ST_IDLE;
						end
					end
					ST_SAMPLE: begin
						cnt_reg <= '0;
						if (smp_done && !smp_start_reg) begin // stale count from an aborted sample ignored
							state_reg <= ST_CONVERT;
						end
					end
					ST_CONVERT: begin
						cnt_reg <= cnt_reg + CNT_W'(1);
						if (cnt_reg == CNT_W'(CONV_CYCLES - 1)) begin
							conv_end_reg <= 1'b1;
							dma_req_reg <= dma_reg && !cur_inj_reg;
							if (continuous_conversion_reg && !cur_inj_reg) begin
								state_reg <= ST_SAMPLE;
								cur_ch_reg <= regular_channel;
								smp_start_reg <= 1'b1;
							end else begin
								state_reg <= ST_IDLE;
							end
						end
					end
					default: state_reg <= ST_OFF;
				endcase
			end
		end
	end

	// outputs, all from flops
	assign rdata = rdata_reg;
	assign conv_start = smp_start_reg;
	assign conv_end = conv_end_reg;
	assign dma_request = dma_req_reg;
	assign dma_enable = dma_reg;
	assign align_left = align_reg;
	assign cal_clear = cal_clear_reg;
	assign conv_status = '{powered: converter_on_reg, sampling: state_reg == ST_SAMPLE,
		converting: state_reg == ST_CONVERT, injected: cur_inj_reg, calibrating: calibrate_reg,
		channel: cur_ch_reg, smp_code: cur_code};

	chk_inj_ext_gate: assert property (smp_start_reg && cur_inj_reg && !$past(inj_from_sw)
		|-> $past(injected_external_trigger_enable_reg))
		else $error("injected start without external enable");
	chk_jsw_clears: assert property (jsw_taken && !ctl_wr |=> !injected_software_start_reg)
		else $error("software start bit not cleared");
	chk_dma_gate: assert property (dma_request |-> $past(dma_reg) && !cur_inj_reg)
		else $error("dma request while dma disabled");
	chk_calibration_reset_drops: assert property ($rose(calibration_reset_reg) |-> ##[1:CALIBRATION_RESET_BOUND] !calibration_reset_reg)
		else $error("calibration reset never finished");
	chk_calibration_reset_waits: assert property (calibration_reset_reg && state_reg == ST_CONVERT |=> $stable(rst_cnt_reg))
		else $error("calibration reset ran during conversion");
	chk_cal_hold: assert property (calibrate_reg && state_reg == ST_CAL && !cal_done && !power_off |=> calibrate_reg)
		else $error("calibration bit dropped early");
	chk_continuous_conversion_repeat: assert property (conv_end && $past(continuous_conversion_reg) && !cur_inj_reg
		&& !$past(power_off) |-> conv_start)
		else $error("continuous mode did not restart");
	chk_wake_only: assert property (state_reg == ST_OFF && ctl_wr && bus.wdata[BIT_ON] |=> !conv_start ##1 !conv_start)
		else $error("power up started a conversion");
	chk_off_stops: assert property (power_off |=> state_reg == ST_OFF && !calibrate_reg)
		else $error("power down did not stop the converter");
	chk_other_bits: assert property (ctl_wr && other_changed && !reg_pending_reg |=> !reg_pending_reg)
		else $error("mixed write started a conversion");

endmodule
`default_nettype wire

// *** core/adcc_pkg.sv ***
// converter control package: register map, field positions, reset values,
// cycle counts and the carrier types shared by the control block.
// assumes one 20 MHz peripheral clock that also clocks the converter core.
package adcc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTL2 = 8'h08;
	localparam logic [7:0] OFS_SMP_HI = 8'h0C;
	localparam logic [7:0] OFS_SMP_LO = 8'h10;

	// control register two field positions
	localparam int BIT_ON = 0;
	localparam int BIT_CONTINUOUS_CONVERSION = 1;
	localparam int BIT_CAL = 2;
	localparam int BIT_CALIBRATION_RESET = 3;
	localparam int BIT_DMA = 8;
	localparam int BIT_ALIGN = 11;
	localparam int JSEL_LSB = 12;
	localparam int BIT_JEXT = 15;
	localparam int BIT_JSW = 21;
	localparam logic [31:0] CTL2_RW_MASK = 32'h0020F90F;
	localparam logic [31:0] CTL2_RESET = 32'h00000000;

	// sample time layout: 3 bits per channel
	localparam int NCH = 18;
	localparam int SMP_W = 3;
	localparam int CH_W = 5;
	localparam int HI_FIRST_CH = 10;
	localparam logic [31:0] SMP_HI_MASK = 32'h00FFFFFF;
	localparam logic [31:0] SMP_LO_MASK = 32'h3FFFFFFF;
	localparam logic [31:0] SMP_RESET = 32'h00000000;

	// sampling length in half converter cycles, index is the code
	localparam int SMP_HALF [8] = '{3, 15, 27, 57, 83, 111, 143, 479};
	localparam int SMP_CNT_W = 9;

	// conversion, calibration and calibration-reset lengths
	localparam int CONV_HALF = 25;
	localparam int CONV_CYCLES = (CONV_HALF + 1) / 2;
	localparam int CAL_CYCLES = 83;
	localparam int CALIBRATION_RESET_CYCLES = 8;
	localparam int CNT_W = 8;

	// injected trigger codes
	localparam logic [2:0] JTRIG_T1_TIMER_TRIGGER_OUTPUT = 3'h0;
	localparam logic [2:0] JTRIG_T1_CC4 = 3'h1;
	localparam logic [2:0] JTRIG_T2_TIMER_TRIGGER_OUTPUT = 3'h2;
	localparam logic [2:0] JTRIG_T2_CC1 = 3'h3;
	localparam logic [2:0] JTRIG_T3_CC4 = 3'h4;
	localparam logic [2:0] JTRIG_T4_TIMER_TRIGGER_OUTPUT = 3'h5;
	localparam logic [2:0] JTRIG_EXT15 = 3'h6;
	localparam logic [2:0] JTRIG_SOFT = 3'h7;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} adcc_bus_t;

	typedef struct packed {
		logic powered;
		logic sampling;
		logic converting;
		logic injected;
		logic calibrating;
		logic [CH_W-1:0] channel;
		logic [SMP_W-1:0] smp_code;
	} adcc_conv_t;

	typedef enum logic [2:0] {ST_OFF, ST_IDLE, ST_CAL, ST_SAMPLE, ST_CONVERT} adcc_state_t;

endpackage

// *** core/adcc_inj_trig.sv ***
// injected trigger selector: picks one event source by code.
// assumes event inputs are one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adcc_inj_trig
	import adcc_pkg::*;
(
	input wire logic [2:0] sel,
	input wire logic ext_en,
	input wire logic sw_start,
	input wire logic [6:0] events,
	output logic go,
	output logic from_sw
);

	// code 111 is the software bit; every other code an external event
	always_comb begin
		from_sw = (sel == JTRIG_SOFT);
		if (from_sw) begin
			go = sw_start;
		end else begin
			go = ext_en && events[sel];
		end
	end

endmodule
`default_nettype wire

// *** core/adcc_smp_timer.sv ***
// sampling phase timer: runs for the cycle count that a sample code selects.
// assumes start is a one-cycle pulse given only while not busy.
`timescale 1ns/1ps
`default_nettype none
module adcc_smp_timer
	import adcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [SMP_W-1:0] code,
	output logic busy,
	output logic done
);

	logic [SMP_CNT_W-1:0] cnt_reg;
	logic [SMP_CNT_W-1:0] len;
	logic [SMP_CNT_W-1:0] chk_len_reg;
	logic [SMP_CNT_W-1:0] chk_age_reg;

	// half cycles round up, converter runs at the block clock
	always_comb begin
		len = SMP_CNT_W'((SMP_HALF[code] + 1) / 2);
	end

	// down counter, done pulses on the last sampling cycle;
	// the start pulse cycle already samples, so load one less
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else if (start) begin
			cnt_reg <= len - SMP_CNT_W'(1);
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - SMP_CNT_W'(1);
		end
	end

	assign busy = (cnt_reg != '0);
	assign done = (cnt_reg == SMP_CNT_W'(1));

	// helper: length asked and cycles since start
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			chk_len_reg <= '0;
			chk_age_reg <= '0;
		end else if (start) begin
			chk_len_reg <= len;
			chk_age_reg <= SMP_CNT_W'(2);
		end else if (busy) begin
			chk_age_reg <= chk_age_reg + SMP_CNT_W'(1);
		end
	end

	chk_smp_length: assert property (@(posedge clk) disable iff (!rst_b) done |-> chk_age_reg == chk_len_reg)
		else $error("sampling length does not match the code");

endmodule
`default_nettype wire

// *** tb/tb_adc_control_and_sample_time.sv ***
// testbench for the converter control block: register access, conversions,
// sample times, calibration, injected triggers.
// assumes the block's package is compiled first; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_and_sample_time
	import adcc_pkg::*;
;
	// sampling lengths in whole clocks, half cycles rounded up
	localparam int SMP_EXP [8] = '{2, 8, 14, 29, 42, 56, 72, 240};
	// channels picked to hit both registers and their edge fields
	localparam int CHS [8] = '{0, 9, 10, 17, 3, 12, 5, 15};
	logic clk;
	logic rst_b;
	adcc_bus_t bus;
	logic [31:0] rdata;
	logic [6:0] inj_events;
	logic [CH_W-1:0] regular_channel;
	logic [CH_W-1:0] injected_channel;
	adcc_conv_t conv_status;
	logic conv_start;
	logic conv_end;
	logic dma_request;
	logic dma_enable;
	logic align_left;
	logic cal_clear;
	int bad_count;
	int n_compared;
	logic [31:0] rv;

	adcc_ctrl i_adcc_ctrl (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .inj_events(inj_events),
		.regular_channel(regular_channel), .injected_channel(injected_channel), .conv_status(conv_status),
		.conv_start(conv_start), .conv_end(conv_end), .dma_request(dma_request), .dma_enable(dma_enable),
		.align_left(align_left), .cal_clear(cal_clear));

	// free-running clock, 50 ns period
	always #25 clk = ~clk;

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s: got %h want %h", $time, msg, got, exp);
		end
	endtask

	// bus cycles: one-cycle strobes, read data sampled in the following cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return conv_start;
			1: return conv_end;
			default: return cal_clear;
		endcase
	endfunction

	// bounded wait for a pulse; running out ends the run as a failure
	task automatic wait_pulse(input int sel, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
			if (n > lim) begin
				bad_count++;
				$display("CHECK FAILED t=%0t wait for pulse %0d ran out", $time, sel);
				end_of_test();
			end
		end while (pick(sel) !== 1'b1);
	endtask

	// the pulse must stay low for lim cycles
	task automatic quiet(input int sel, input int lim, input string msg);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			#1 if (pick(sel) !== 1'b0) seen = 1'b1;
		end
		chk(seen, 0, msg);
	endtask

	// counts sampling and converting cycles up to the end pulse
	task automatic measure(output int ns, output int nc);
		ns = 0;
		nc = 0;
		for (int i = 0; i < 400; i++) begin
			if (conv_status.sampling === 1'b1) ns++;
			if (conv_status.converting === 1'b1) nc++;
			if (conv_end === 1'b1) return;
			@(posedge clk);
			#1;
		end
		bad_count++;
		$display("CHECK FAILED t=%0t conversion never ended", $time);
		end_of_test();
	endtask

	task automatic run_conv(input logic [31:0] ctl, input int samp, input string msg);
		int n;
		int ns;
		int nc;
		wr(OFS_CTL2, ctl);
		wait_pulse(0, 6, n);
		measure(ns, nc);
		chk(ns, samp, msg);
		chk(nc, CONV_CYCLES, "conversion length");
	endtask

	// one channel gets code k, every other channel code 7, so a misplaced field shows
	task automatic set_code(input int ch, input logic [2:0] k);
		logic [31:0] hi;
		logic [31:0] lo;
		int pos;
		hi = SMP_HI_MASK;
		lo = SMP_LO_MASK;
		if (ch < HI_FIRST_CH) begin
			pos = ch * 3;
			lo = (lo & ~(32'h7 << pos)) | (32'(k) << pos);
		end else begin
			pos = (ch - HI_FIRST_CH) * 3;
			hi = (hi & ~(32'h7 << pos)) | (32'(k) << pos);
		end
		wr(OFS_SMP_HI, hi);
		wr(OFS_SMP_LO, lo);
	endtask

	task automatic t_reset();
		rd(OFS_CTL2, rv);
		chk(rv, 32'h00000000, "control after reset");
		rd(OFS_SMP_HI, rv);
		chk(rv, 32'h00000000, "sample hi after reset");
		rd(OFS_SMP_LO, rv);
		chk(rv, 32'h00000000, "sample lo after reset");
		rd(8'h04, rv);
		chk(rv, 32'h00000000, "unmapped read");
		chk(dma_enable, 0, "dma after reset");
		$display("test reset done");
	endtask

	task automatic t_regs();
		wr(OFS_SMP_HI, 32'hFFFFFFFF);
		rd(OFS_SMP_HI, rv);
		chk(rv, SMP_HI_MASK, "sample hi width");
		wr(OFS_SMP_LO, 32'hFFFFFFFF);
		rd(OFS_SMP_LO, rv);
		chk(rv, SMP_LO_MASK, "sample lo width");
		wr(8'h04, 32'hFFFFFFFF);
		wr(OFS_CTL2, 32'hFF1F09F0);
		#1 chk(dma_enable, 1, "dma bit set");
		chk(align_left, 1, "align bit set");
		rd(OFS_CTL2, rv);
		chk(rv, 32'h00000900, "control readback");
		wr(OFS_CTL2, 32'h00000000);
		#1 chk(dma_enable, 0, "dma bit clear");
		$display("test regs done");
	endtask

	task automatic t_samp();
		wr(OFS_CTL2, 32'h00000001);
		quiet(0, 10, "power-up started a conversion");
		chk(conv_status.powered, 1, "powered");
		for (int k = 0; k < 8; k++) begin
			set_code(CHS[k], 3'(k));
			regular_channel <= 5'(CHS[k]);
			run_conv(32'h00000001, SMP_EXP[k], "sampling length");
			chk(conv_status.channel, 32'(CHS[k]), "channel");
			chk(conv_status.smp_code, 32'(k), "sample code of channel");
		end
		$display("test sample times done");
	endtask

	task automatic t_only_on();
		set_code(4, 3'h0);
		regular_channel <= 5'd4;
		wr(OFS_CTL2, 32'h00000101);
		quiet(0, 20, "start with another bit changed");
		run_conv(32'h00000101, 2, "sampling length");
		chk(dma_request, 1, "dma request at end");
		quiet(0, 30, "single mode repeated");
		wr(OFS_CTL2, 32'h00000001);
		quiet(0, 10, "dma clear started a conversion");
		$display("test start rule done");
	endtask

	task automatic t_contin();
		int n;
		wr(OFS_CTL2, 32'h00000003);
		quiet(0, 10, "mode change started a conversion");
		wr(OFS_CTL2, 32'h00000003);
		for (int i = 0; i < 3; i++) begin
			wait_pulse(1, 20, n);
		end
		wr(OFS_CTL2, 32'h00000001);
		repeat (40) @(posedge clk);
		quiet(0, 40, "conversions after leaving continuous");
		$display("test continuous done");
	endtask

	task automatic t_abort();
		int n;
		set_code(0, 3'h7);
		regular_channel <= 5'd0;
		wr(OFS_CTL2, 32'h00000001);
		wait_pulse(0, 6, n);
		repeat (5) @(posedge clk);
		wr(OFS_CTL2, 32'h00000000);
		@(posedge clk);
		#1 chk({conv_status.powered, conv_status.sampling, conv_status.converting}, 0, "abort");
		quiet(1, 300, "aborted conversion ended");
		wr(OFS_CTL2, 32'h00000001);
		wr(OFS_CTL2, 32'h00000005);
		repeat (5) @(posedge clk);
		wr(OFS_CTL2, 32'h00000000);
		@(posedge clk);
		#1 chk(conv_status.calibrating, 0, "calibration abort");
		$display("test power down done");
	endtask

	task automatic t_calib();
		int n;
		wr(OFS_CTL2, 32'h00000001);
		wr(OFS_CTL2, 32'h00000005);
		rd(OFS_CTL2, rv);
		chk(rv, 32'h00000005, "calibration bit held");
		n = 2;
		while (conv_status.calibrating === 1'b1 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk(n >= CAL_CYCLES - 1 && n <= CAL_CYCLES + 1, 1, "calibration length");
		rd(OFS_CTL2, rv);
		chk(rv, 32'h00000001, "calibration bit dropped");
		wr(OFS_CTL2, 32'h00000009);
		wait_pulse(2, 30, n);
		chk(n >= CALIBRATION_RESET_CYCLES && n <= CALIBRATION_RESET_CYCLES + 3, 1, "calibration reset length");
		rd(OFS_CTL2, rv);
		chk(rv, 32'h00000001, "calibration reset bit dropped");
		// long sampling so the reset request lands mid conversion
		wr(OFS_CTL2, 32'h00000001);
		wait_pulse(0, 6, n);
		wr(OFS_CTL2, 32'h00000009);
		quiet(2, 200, "calibration reset during conversion");
		wait_pulse(2, 300, n);
		$display("test calibration done");
	endtask

	task automatic pulse_ev(input int idx);
		@(posedge clk);
		inj_events <= 7'(1 << idx);
		@(posedge clk);
		inj_events <= 7'h00;
	endtask

	task automatic t_inj();
		int n;
		set_code(5, 3'h0);
		injected_channel <= 5'd5;
		for (int c = 0; c < 7; c++) begin
			wr(OFS_CTL2, 32'h00000001 | (32'h1 << BIT_JEXT) | (32'(c) << JSEL_LSB));
			pulse_ev((c + 1) % 7);
			// an event start shows in the cycle right after the event edge, so look there first
			#1 chk(conv_start, 0, "unselected event started at once");
			quiet(0, 5, "unselected event started");
			pulse_ev(c);
			#1 chk(conv_start, 1, "selected event did not start");
			chk(conv_status.injected, 1, "injected flag");
			chk(conv_status.channel, 5, "injected channel");
			wait_pulse(1, 40, n);
		end
		wr(OFS_CTL2, 32'h00000001);
		pulse_ev(0);
		#1 chk(conv_start, 0, "event with trigger disabled at once");
		quiet(0, 10, "event with trigger disabled");
		wr(OFS_CTL2, 32'h00000001 | (32'h7 << JSEL_LSB) | (32'h1 << BIT_JSW));
		wait_pulse(0, 5, n);
		chk(conv_status.injected, 1, "software injected flag");
		rd(OFS_CTL2, rv);
		chk(rv[BIT_JSW], 0, "software start bit cleared");
		wait_pulse(1, 40, n);
		$display("test injected done");
	endtask

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		bus = '0;
		inj_events = 7'h00;
		regular_channel = 5'd0;
		injected_channel = 5'd0;
		bad_count = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_regs();
		t_samp();
		t_only_on();
		t_contin();
		t_abort();
		t_calib();
		t_inj();
		end_of_test();
	end
endmodule
`default_nettype wire
